// ==== unsigned_saturating_simd_alu_test.sv ====
// Self-checking bench for the unsigned saturating SIMD datapath
`timescale 1ns/100ps
`default_nettype none
`include "usa_regs.svh"

module unsigned_saturating_simd_alu_test;

   // ************************************************************
   // Stimulus, sampled inputs and bookkeeping
   // ************************************************************
   logic                     core_clk = 1'b0;  // 100 MHz core clock
   logic                     sys_rst = 1'b1;   // Held high from time zero
   logic                     clk_en = 1'b0;
   logic                     issue_valid = 1'b0;
   usa_pkg::usa_op_t         issue_op = usa_pkg::unsigned_add_sub_exchange_saturate;
   logic [31:0]              first_operand_register = 32'h0000_0000;
   logic [31:0]              second_operand_register = 32'h0000_0000;
   logic [4:0]               shift_amount = 5'h00;
   logic [3:0]               first_operand_index = 4'h0;
   logic                     dest_given = 1'b0;
   logic [3:0]               dest_index = 4'h0;
   logic [3:0]               flags_in = 4'h0;
   logic                     result_valid;
   logic [31:0]              result_data;
   logic [3:0]               result_dest;
   logic [3:0]               flags_out;
   logic [31:0]              exp_q[$];         // Expected results, oldest first
   logic                     live = 1'b0;      // Checks start once reset is seen
   logic                     en_s = 1'b0;      // Inputs as seen at the last edge
   logic                     rst_s = 1'b0;
   logic                     vld_s = 1'b0;
   logic [3:0]               flg_s = 4'h0;
   logic [3:0]               dst_s = 4'h0;
   logic [40:0]              prev_out;         // Outputs at the previous check
   int                       n_mismatch = 0;
   int                       tests_run = 0;
   int                       cycles = 0;

   usa_alu u_dut (
      .core_clk                (core_clk),
      .sys_rst                 (sys_rst),
      .clk_en                  (clk_en),
      .issue_valid             (issue_valid),
      .issue_op                (issue_op),
      .first_operand_register  (first_operand_register),
      .second_operand_register (second_operand_register),
      .shift_amount            (shift_amount),
      .first_operand_index     (first_operand_index),
      .dest_given              (dest_given),
      .dest_index              (dest_index),
      .flags_in                (flags_in),
      .result_valid            (result_valid),
      .result_data             (result_data),
      .result_dest             (result_dest),
      .flags_out               (flags_out)
   );

   // Clock: toggle every half period
   always #5 core_clk = ~core_clk;

   // ************************************************************
   // Reference model and helpers
   // ************************************************************
   // Clamp one lane; the 17-bit sum keeps the true result before clamping
   function automatic logic [15:0] sat(input logic [15:0] x, input logic [15:0] y,
                                       input logic sub, input logic [16:0] mx);
      logic [16:0] t;
      t = sub ? {1'b0, x} - {1'b0, y} : {1'b0, x} + {1'b0, y};
      if (sub) begin
         return t[16] ? 16'h0000 : t[15:0];
      end
      return (t > mx) ? mx[15:0] : t[15:0];
   endfunction

   // Whole-word expectation for one operation
   function automatic logic [31:0] ref_calc(input usa_pkg::usa_op_t op, input logic [31:0] a,
                                            input logic [31:0] b, input logic [4:0] sh);
      logic [31:0] r;
      logic [31:0] l;
      logic [31:0] s;
      logic        sb;
      l = b << sh;
      // A zero field means a full 32-bit arithmetic shift: only sign bits remain
      s = (sh == 5'h00) ? {32{b[31]}} : 32'($signed(b) >>> sh);
      sb = (op == usa_pkg::unsigned_byte_lane_sat_sub)
           || (op == usa_pkg::unsigned_halfword_lane_sat_sub);
      r = 32'h0000_0000;
      case (op)
         usa_pkg::unsigned_add_sub_exchange_saturate:
            r = {sat(a[31:16], b[15:0], 1'b0, 17'h0FFFF), sat(a[15:0], b[31:16], 1'b1, 17'h0FFFF)};
         usa_pkg::unsigned_sub_add_exchange_saturate:
            r = {sat(a[31:16], b[15:0], 1'b1, 17'h0FFFF), sat(a[15:0], b[31:16], 1'b0, 17'h0FFFF)};
         usa_pkg::pack_bottom_top_halfwords:
            r = {l[31:16], a[15:0]};
         usa_pkg::pack_top_bottom_halfwords:
            r = {a[31:16], s[15:0]};
         usa_pkg::unsigned_byte_lane_sat_add, usa_pkg::unsigned_byte_lane_sat_sub: begin
            for (int k = 0; k < 4; k++) begin
               r[8*k +: 8] = 8'(sat({8'h00, a[8*k +: 8]}, {8'h00, b[8*k +: 8]}, sb, 17'h000FF));
            end
         end
         default: begin
            for (int k = 0; k < 2; k++) begin
               r[16*k +: 16] = sat(a[16*k +: 16], b[16*k +: 16], sb, 17'h0FFFF);
            end
         end
      endcase
      return r;
   endfunction

   // One comparison; prints and counts on a miss
   task automatic check(input logic ok, input string msg);
      tests_run++;
      if (ok !== 1'b1) begin
         n_mismatch++;
         $display("wrong value at %0t: %s", $time, msg);
      end
   endtask

   // Present one cycle of inputs and note the result it should give
   task automatic issue(input usa_pkg::usa_op_t op, input logic [31:0] a, input logic [31:0] b,
                        input logic [4:0] sh, input logic en = 1'b1, input logic vl = 1'b1,
                        input logic rs = 1'b0);
      @(posedge core_clk);
      sys_rst <= rs;
      clk_en <= en;
      issue_valid <= vl;
      issue_op <= op;
      first_operand_register <= a;
      second_operand_register <= b;
      shift_amount <= sh;
      // Indices are plain register numbers here; none plays stack pointer or PC
      dest_given <= 1'($urandom);
      dest_index <= 4'($urandom);
      first_operand_index <= 4'($urandom);
      flags_in <= 4'($urandom);
      // Only an enabled, valid, non-reset cycle produces a result
      if (en && vl && !rs) begin
         exp_q.push_back(ref_calc(op, a, b, sh));
      end
   endtask

   // Verdict and end of run
   task automatic complete_run;
      if (n_mismatch == 0 && tests_run > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask

   // ************************************************************
   // Output watcher
   // ************************************************************
   // Remember what the datapath saw at each rising edge
   always @(posedge core_clk) begin
      en_s <= clk_en;
      rst_s <= sys_rst;
      vld_s <= issue_valid;
      flg_s <= flags_in;
      dst_s <= dest_given ? dest_index : first_operand_index;
   end

   // Compare settled outputs mid-cycle
   always @(negedge core_clk) begin
      if (live && rst_s) begin
         check({result_valid, result_data, result_dest, flags_out} === 41'h0, "reset value");
      end else if (live && !en_s) begin
         check({result_valid, result_data, result_dest, flags_out} === prev_out, "not frozen");
      end else if (live) begin
         check(flags_out === flg_s, "flags changed");
         check(result_dest === dst_s, "destination");
         check(result_valid === vld_s, "valid timing");
         if (result_valid === 1'b1) begin
            check(exp_q.size() > 0, "result without issue");
            if (exp_q.size() > 0) begin
               check(result_data === exp_q.pop_front(), "lane result");
            end
         end
      end
      prev_out = {result_valid, result_data, result_dest, flags_out};
   end

   // Hang guard
   always @(posedge core_clk) begin
      cycles++;
      if (cycles == 3000) begin
         n_mismatch++;
         complete_run();
      end
   end

   // ************************************************************
   // Main sequence
   // ************************************************************
   initial begin
      void'($urandom(36));
      @(posedge core_clk);
      live = 1'b1;
      // Reset stands over three rising edges in all
      repeat (1) @(posedge core_clk);
      // Directed corners, back to back
      issue(usa_pkg::unsigned_add_sub_exchange_saturate,
            32'hFFF0_0005, 32'h0006_0020, 5'h00);
      issue(usa_pkg::unsigned_add_sub_exchange_saturate,
            32'h1000_0009, 32'h0004_0100, 5'h00);
      issue(usa_pkg::unsigned_sub_add_exchange_saturate,
            32'h0003_FFF0, 32'h0100_0004, 5'h00);
      issue(usa_pkg::unsigned_sub_add_exchange_saturate,
            32'h0900_0010, 32'h0020_0100, 5'h00);
      issue(usa_pkg::unsigned_halfword_lane_sat_add,
            32'hFFFF_0001, 32'h0001_0002, 5'h00);
      issue(usa_pkg::unsigned_byte_lane_sat_add,
            32'hFF80_017F, 32'h0181_FF01, 5'h00);
      issue(usa_pkg::unsigned_halfword_lane_sat_sub,
            32'h0001_8000, 32'h0002_7FFF, 5'h00);
      issue(usa_pkg::unsigned_byte_lane_sat_sub,
            32'h0080_0001, 32'h0101_0002, 5'h00);
      issue(usa_pkg::pack_bottom_top_halfwords,
            32'h1234_5678, 32'h9ABC_DEF1, 5'h00);
      issue(usa_pkg::pack_bottom_top_halfwords,
            32'h1234_5678, 32'h9ABC_DEF1, 5'h01);
      issue(usa_pkg::pack_bottom_top_halfwords,
            32'h1234_5678, 32'h0000_0001, 5'h1F);
      issue(usa_pkg::pack_top_bottom_halfwords,
            32'h1234_5678, 32'h8000_0000, 5'h00);
      issue(usa_pkg::pack_top_bottom_halfwords,
            32'h1234_5678, 32'h7FFF_0000, 5'h00);
      issue(usa_pkg::pack_top_bottom_halfwords,
            32'h1234_5678, 32'h8765_4321, 5'h10);
      // Random traffic with stalls and one reset in mid-run
      for (int i = 0; i < 400; i++) begin
         issue(usa_pkg::usa_op_t'($urandom_range(7)), $urandom, $urandom, 5'($urandom),
               $urandom_range(3) != 0, 1'($urandom_range(3) != 0), i == 200);
      end
      issue(usa_pkg::unsigned_add_sub_exchange_saturate, 32'h0, 32'h0, 5'h00, 1'b1, 1'b0);
      repeat (3) @(posedge core_clk);
      check(exp_q.size() == 0, "results missing");
      complete_run();
   end

endmodule
`default_nettype wire

// ==== usa_alu.sv ====
// Unsigned saturating SIMD add/subtract and halfword pack datapath
// ************************************************************
// What this block does
// - Exchange add-sub: top gets a.hi plus b.lo
// - Exchange add-sub: bottom gets a.lo minus b.hi
// - Exchange sub-add: top gets a.hi minus b.lo
// - Exchange sub-add: bottom gets a.lo plus b.hi
// - Exchange sums clamp to all-ones on overflow
// - Halfword add: two lanes clamp to 16 bits
// - Byte add: four lanes clamp to 8 bits
// - Halfword subtract: two lanes clamp at zero
// - Byte subtract: four lanes clamp at zero
// - Negative gives zero, overflow gives lane maximum
// - Condition flags stay unchanged
// - Omitted destination writes first operand register
// - Bottom-top pack: left shift 0 to 31
// - Top-bottom pack: arithmetic right, zero means 32
// - Bottom-top pack: a.lo low, shifted top high
// - Top-bottom pack: a.hi high, shifted bottom low
// ************************************************************
`timescale 1ns/100ps
`default_nettype none
`include "usa_regs.svh"

module usa_alu (
   input  wire logic                       core_clk,
   input  wire logic                       sys_rst,
   input  wire logic                       clk_en,
   input  wire logic                       issue_valid,
   input  wire usa_pkg::usa_op_t           issue_op,
   input  wire logic [`USA_WORD_W-1:0]     first_operand_register,
   input  wire logic [`USA_WORD_W-1:0]     second_operand_register,
   input  wire logic [`USA_SHAMT_W-1:0]    shift_amount,
   input  wire logic [`USA_REG_IDX_W-1:0]  first_operand_index,
   input  wire logic                       dest_given,
   input  wire logic [`USA_REG_IDX_W-1:0]  dest_index,
   input  wire logic [3:0]                 flags_in,
   output logic                            result_valid,
   output logic      [`USA_WORD_W-1:0]     result_data,
   output logic      [`USA_REG_IDX_W-1:0]  result_dest,
   output logic      [3:0]                 flags_out
);

   // ************************************************************
   // State
   // ************************************************************
   // All registered state in one record
   typedef struct packed {
      logic                      valid;
      logic [`USA_WORD_W-1:0]    data;
      logic [`USA_REG_IDX_W-1:0] dest;
      logic [3:0]                flags;
   } usa_state_t;

   usa_state_t state_q;                       // Registered outputs
   usa_state_t state_d;                       // Next value

   // Operand halves and lane selections
   logic [`USA_HALF_W-1:0] a_hi, a_lo, b_hi, b_lo;
   logic [`USA_HALF_W-1:0] hx_a [2];          // Halfword lane operands A
   logic [`USA_HALF_W-1:0] hx_b [2];          // Halfword lane operands B
   logic                   hx_sub [2];        // Halfword lane direction
   logic [`USA_HALF_W-1:0] hx_y [2];          // Halfword lane results
   logic [`USA_BYTE_W-1:0] by_y [4];          // Byte lane results
   logic                   byte_sub;          // Byte lanes subtract
   logic [`USA_WORD_W-1:0] shl_val;           // Left-shifted second operand
   logic [`USA_WORD_W-1:0] asr_val;           // Right-shifted second operand
   logic [5:0]             asr_amt;           // Decoded right shift count

   assign a_hi = first_operand_register[`USA_HALF_HI +: `USA_HALF_W];
   assign a_lo = first_operand_register[`USA_HALF_LO +: `USA_HALF_W];
   assign b_hi = second_operand_register[`USA_HALF_HI +: `USA_HALF_W];
   assign b_lo = second_operand_register[`USA_HALF_LO +: `USA_HALF_W];

   // ************************************************************
   // Halfword lane operand steering
   // ************************************************************
   // Index 1 is the top lane, index 0 the bottom lane. Exchange forms
   // cross the second operand's halves before they reach the lanes.
   always_comb begin
      hx_a[1] = a_hi;
      hx_a[0] = a_lo;
      hx_b[1] = b_hi;
      hx_b[0] = b_lo;
      hx_sub[1] = 1'b0;
      hx_sub[0] = 1'b0;
      case (issue_op)
         usa_pkg::unsigned_add_sub_exchange_saturate: begin
            hx_b[1]   = b_lo;
            hx_b[0]   = b_hi;
            hx_sub[0] = 1'b1;
         end
         usa_pkg::unsigned_sub_add_exchange_saturate: begin
            hx_b[1]   = b_lo;
            hx_sub[1] = 1'b1;
            hx_b[0]   = b_hi;
         end
         usa_pkg::unsigned_halfword_lane_sat_sub: begin
            hx_sub[1] = 1'b1;
            hx_sub[0] = 1'b1;
         end
         default: begin
            hx_sub[1] = 1'b0;
            hx_sub[0] = 1'b0;
         end
      endcase
   end

   assign byte_sub = (issue_op == usa_pkg::unsigned_byte_lane_sat_sub);

   // ************************************************************
   // Independent saturating lanes
   // ************************************************************
   // Each lane is its own adder so no carry can leak across lanes
   for (genvar h = 0; h < 2; h++) begin : g_half
      usa_sat_lane #(.W(`USA_HALF_W)) u_lane (
         .a   (hx_a[h]),
         .b   (hx_b[h]),
         .sub (hx_sub[h]),
         .y   (hx_y[h])
      );
   end

   for (genvar k = 0; k < 4; k++) begin : g_byte
      usa_sat_lane #(.W(`USA_BYTE_W)) u_lane (
         .a   (first_operand_register[k*`USA_BYTE_W +: `USA_BYTE_W]),
         .b   (second_operand_register[k*`USA_BYTE_W +: `USA_BYTE_W]),
         .sub (byte_sub),
         .y   (by_y[k])
      );
   end

   // ************************************************************
   // Pack shifters
   // ************************************************************
   // Zero in the field means shift by 32, which fills with the sign bit
   assign asr_amt = (shift_amount == '0) ? `USA_ASR_FULL
                                          : {1'b0, shift_amount};
   assign shl_val = second_operand_register << shift_amount;
   assign asr_val = $signed(second_operand_register) >>> asr_amt;

   // ************************************************************
   // Next-state logic
   // ************************************************************
   always_comb begin
      state_d = state_q;
      if (clk_en) begin
         state_d.valid = issue_valid;
         // Flags pass through untouched by every operation here
         state_d.flags = flags_in;
         // Omitted destination falls back to the first operand register
         state_d.dest  = dest_given ? dest_index : first_operand_index;
         if (issue_valid) begin
            case (issue_op)
               usa_pkg::unsigned_byte_lane_sat_add,
               usa_pkg::unsigned_byte_lane_sat_sub: begin
                  state_d.data = {by_y[3], by_y[2], by_y[1], by_y[0]};
               end
               usa_pkg::pack_bottom_top_halfwords: begin
                  state_d.data = {shl_val[`USA_HALF_HI +: `USA_HALF_W], a_lo};
               end
               usa_pkg::pack_top_bottom_halfwords: begin
                  state_d.data = {a_hi, asr_val[`USA_HALF_LO +: `USA_HALF_W]};
               end
               default: begin
                  state_d.data = {hx_y[1], hx_y[0]};
               end
            endcase
         end
      end
      if (sys_rst) begin
         state_d.valid = 1'b0;
         state_d.data  = `USA_RESULT_RST;
         state_d.dest  = '0;
         state_d.flags = '0;
      end
   end

   // ************************************************************
   // State register
   // ************************************************************
   // Reset is synchronous and is folded into the next-state logic above
   always_ff @(posedge core_clk) begin
      state_q <= state_d;
   end

   assign result_valid = state_q.valid;
   assign result_data  = state_q.data;
   assign result_dest  = state_q.dest;
   assign flags_out    = state_q.flags;

   // ************************************************************
   // Assertions
   // ************************************************************
   property p_exch_top_sat;
      @(posedge core_clk) disable iff (sys_rst)
      (clk_en && issue_valid && issue_op == usa_pkg::unsigned_add_sub_exchange_saturate
       && (32'(a_hi) + 32'(b_lo)) > 32'h0000_FFFF)
      |=> result_data[31:16] == 16'hFFFF;
   endproperty
   a_exch_top_sat: assert property (p_exch_top_sat) else $error("exchange top sum");

   property p_exch_bot_sub;
      @(posedge core_clk) disable iff (sys_rst)
      (clk_en && issue_valid && issue_op == usa_pkg::unsigned_add_sub_exchange_saturate)
      |=> result_data[15:0] == (($past(a_lo) < $past(b_hi)) ? 16'h0000
                                : 16'($past(a_lo) - $past(b_hi)));
   endproperty
   a_exch_bot_sub: assert property (p_exch_bot_sub) else $error("exchange bottom");

   property p_sax_top;
      @(posedge core_clk) disable iff (sys_rst)
      (clk_en && issue_valid && issue_op == usa_pkg::unsigned_sub_add_exchange_saturate
       && a_hi < b_lo) |=> result_data[31:16] == 16'h0000;
   endproperty
   a_sax_top: assert property (p_sax_top) else $error("sub-add top not zero");

   property p_byte_add;
      @(posedge core_clk) disable iff (sys_rst)
      (clk_en && issue_valid && issue_op == usa_pkg::unsigned_byte_lane_sat_add)
      |=> result_data[7:0] == ((9'($past(first_operand_register[7:0]))
           + 9'($past(second_operand_register[7:0]))) > 9'h0FF ? 8'hFF
           : 8'($past(first_operand_register[7:0]) + $past(second_operand_register[7:0])));
   endproperty
   a_byte_add: assert property (p_byte_add) else $error("byte add lane 0 wrong");

   property p_half_sub;
      @(posedge core_clk) disable iff (sys_rst)
      (clk_en && issue_valid && issue_op == usa_pkg::unsigned_halfword_lane_sat_sub
       && a_hi < b_hi) |=> result_data[31:16] == 16'h0000;
   endproperty
   a_half_sub: assert property (p_half_sub) else $error("halfword sub not clamped");

   property p_flags;
      @(posedge core_clk) disable iff (sys_rst)
      clk_en |=> flags_out == $past(flags_in);
   endproperty
   a_flags: assert property (p_flags) else $error("flags altered");

   property p_dest;
      @(posedge core_clk) disable iff (sys_rst)
      (clk_en && !dest_given) |=> result_dest == $past(first_operand_index);
   endproperty
   a_dest: assert property (p_dest) else $error("default destination wrong");

   property p_pkbt;
      @(posedge core_clk) disable iff (sys_rst)
      (clk_en && issue_valid && issue_op == usa_pkg::pack_bottom_top_halfwords
       && shift_amount == '0)
      |=> result_data == {$past(b_hi), $past(a_lo)};
   endproperty
   a_pkbt: assert property (p_pkbt) else $error("bottom-top pack wrong");

   property p_pktb32;
      @(posedge core_clk) disable iff (sys_rst)
      (clk_en && issue_valid && issue_op == usa_pkg::pack_top_bottom_halfwords
       && shift_amount == '0)
      |=> result_data[15:0] == {16{$past(second_operand_register[31])}}
          && result_data[31:16] == $past(a_hi);
   endproperty
   a_pktb32: assert property (p_pktb32) else $error("top-bottom pack of 32 wrong");

   c_byte_sub: cover property (@(posedge core_clk)
      clk_en && issue_valid && issue_op == usa_pkg::unsigned_byte_lane_sat_sub);
   c_exch: cover property (@(posedge core_clk)
      clk_en && issue_valid && issue_op == usa_pkg::unsigned_sub_add_exchange_saturate);
   c_pack: cover property (@(posedge core_clk)
      clk_en && issue_valid && issue_op == usa_pkg::pack_top_bottom_halfwords);

endmodule

`default_nettype wire

// ==== usa_pkg.sv ====
// Types for the unsigned saturating SIMD datapath
`default_nettype none

package usa_pkg;

   // ************************************************************
   // Operation select
   // ************************************************************
   typedef enum logic [2:0] {
      unsigned_add_sub_exchange_saturate  = 3'h0,
      unsigned_sub_add_exchange_saturate  = 3'h1,
      unsigned_byte_lane_sat_add          = 3'h2,
      unsigned_halfword_lane_sat_add      = 3'h3,
      unsigned_byte_lane_sat_sub          = 3'h4,
      unsigned_halfword_lane_sat_sub      = 3'h5,
      pack_bottom_top_halfwords           = 3'h6,
      pack_top_bottom_halfwords           = 3'h7
   } usa_op_t;

endpackage

`default_nettype wire

// ==== usa_regs.svh ====
// Constants for the unsigned saturating SIMD datapath
`ifndef USA_REGS_SVH
`define USA_REGS_SVH

// ************************************************************
// Lane geometry
// ************************************************************
`define USA_WORD_W       32
`define USA_HALF_W       16
`define USA_BYTE_W       8
`define USA_HALF_LO      0
`define USA_HALF_HI      16

// ************************************************************
// Shift field, register index width and reset values
// ************************************************************
`define USA_SHAMT_W      5
`define USA_ASR_FULL     6'h20
`define USA_REG_IDX_W    4
`define USA_RESULT_RST   32'h0000_0000

`endif

// ==== usa_sat_lane.sv ====
// One unsigned saturating add or subtract lane of configurable width
`timescale 1ns/100ps
`default_nettype none

module usa_sat_lane #(
   parameter int W = 8
) (
   input  wire logic [W-1:0] a,
   input  wire logic [W-1:0] b,
   input  wire logic         sub,
   output logic      [W-1:0] y
);

   // One extra bit holds the true carry or borrow of this lane only
   logic [W:0] wide;

   // ************************************************************
   // Widened arithmetic and clamp
   // ************************************************************
   always_comb begin
      if (sub) begin
         wide = {1'b0, a} - {1'b0, b};
         // A borrow means the true difference was negative: clamp to zero
         y    = wide[W] ? '0 : wide[W-1:0];
      end else begin
         wide = {1'b0, a} + {1'b0, b};
         // A carry means overflow: clamp to the all-ones maximum
         y    = wide[W] ? '1 : wide[W-1:0];
      end
   end

endmodule

`default_nettype wire
